// File: vsd_top.sv
// top: vme slave decode, interrupter, arbitration and local straps
`timescale 1ns/100ps
`default_nettype none
module vsd_top
  import vsd_pkg::*;
#(
  parameter int unsigned RTC_BASE_CYC = RTC_MIN_CYC
)(
  // clock, reset, enable
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // address and space straps (1 = installed)
  input  wire logic        program_space_strap,
  input  wire logic        data_space_strap,
  input  wire logic        standard_space_strap,
  input  wire logic        supervisor_space_strap,
  input  wire logic [7:0]  base_mid_address_straps,
  input  wire logic [7:0]  base_upper_address_straps,
  input  wire logic        base_bit15_strap,
  input  wire logic        base_bit14_strap,
  // interrupt straps
  input  wire logic [6:0]  irq_request_level_straps,
  input  wire logic        iack_level_strap_msb,
  input  wire logic        iack_level_strap_mid,
  input  wire logic        iack_level_strap_lsb,
  input  wire logic [7:0]  vector_byte_straps,
  // misc straps
  input  wire logic        watchdog_enable_strap,
  input  wire logic        halt_report_strap,
  input  wire logic        grant_level3_strap,
  input  wire logic        grant_filter_strap,
  input  wire logic        boot_rom_size_strap,
  input  wire logic        debug_board_present,
  // vme slave cycle
  input  wire logic        vme_as,
  input  wire logic        vme_iack,
  input  wire logic [5:0]  vme_am,
  input  wire logic [31:0] vme_addr,
  input  wire logic [2:0]  vme_iack_level,
  output logic             slave_sel_q,
  output logic             vme_dtack_q,
  output logic             vme_data_oe_q,
  output logic [7:0]       vme_data_q,
  // interrupt request
  input  wire logic        irq_raise,
  output logic [7:0]       vme_irq_q,
  output logic [2:0]       irq_level_q,
  // arbitration
  input  wire logic [3:0]  vme_bg_in,
  output logic [3:0]       vme_bg_out_q,
  output logic [1:0]       grant_level_q,
  output logic             bus_granted_q,
  // halt and watchdog
  input  wire logic        cpu_halt,
  input  wire logic        wdog_kick,
  output logic             sysfail_q,
  output logic             wdog_enabled_q,
  output logic             wdog_irq_q,
  // local processor decode
  input  wire logic [23:0] cpu_addr,
  input  wire logic        cpu_strobe,
  input  wire logic        cpu_we,
  input  wire logic [2:0]  rtc_sel_data,
  output logic             rtc_cs_q,
  output logic             boot_cs_q,
  output logic [2:0]       rtc_sel_q,
  // local memory parity
  input  wire logic [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_rparity,
  input  wire logic        mem_rd_valid,
  output logic             mem_wparity_q,
  output logic             parity_err_q
);

  // ****************************************************************
  // address modifier and base decode
  // ****************************************************************
  logic        ext_mode;
  logic        space_ok;
  logic        priv_ok;
  logic        kind_ok;
  logic        addr_ok;
  logic [2:0]  am_code;
  logic [31:0] base;
  logic        hit;

  assign ext_mode = !standard_space_strap;
  assign am_code  = vme_am[2:0];
  assign space_ok = (vme_am & AM_SPACE_MASK) ==
                    (ext_mode ? AM_EXT_BASE : AM_STD_BASE);
  assign priv_ok  = supervisor_space_strap ?
                    (am_code == AM_CODE_SUP_D || am_code == AM_CODE_SUP_P) :
                    (am_code == AM_CODE_USER_D || am_code == AM_CODE_USER_P);
  // program and data each enabled by their own strap
  assign kind_ok  =
    (program_space_strap &&
     (am_code == AM_CODE_SUP_P || am_code == AM_CODE_USER_P)) ||
    (data_space_strap &&
     (am_code == AM_CODE_SUP_D || am_code == AM_CODE_USER_D));
  // installed strap means address bit zero
  assign base = {~base_upper_address_straps, ~base_mid_address_straps,
                 ~base_bit15_strap, ~base_bit14_strap,
                 14'h0000};
  assign addr_ok =
    (vme_addr[UPPER_LSB-1:WIN_LSB] == base[UPPER_LSB-1:WIN_LSB]) &&
    (!ext_mode || vme_addr[31:UPPER_LSB] == base[31:UPPER_LSB]);
  assign hit = vme_as && !vme_iack && space_ok && priv_ok &&
               kind_ok && addr_ok;

  // ****************************************************************
  // interrupter
  // ****************************************************************
  vsd_irq_if irq_link ();

  logic [2:0] req_level;
  logic [2:0] ack_level;

  // lowest installed pair wins if straps are illegally doubled
  always_comb begin
    req_level = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (irq_request_level_straps[i]) begin
        req_level = 3'(i + 1);
      end
    end
  end

  // removed strap reads one
  assign ack_level = {~iack_level_strap_msb, ~iack_level_strap_mid,
                      ~iack_level_strap_lsb};

  assign irq_link.raise      = irq_raise && (req_level == ack_level);
  assign irq_link.level      = req_level;
  assign irq_link.vector     = vector_byte_straps;
  assign irq_link.iack_cycle = vme_as && vme_iack;
  assign irq_link.iack_level = vme_iack_level;

  vsd_interrupter u_irq (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .bus     (irq_link)
  );

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      vme_irq_q   <= 8'h00;
      irq_level_q <= 3'h0;
    end else if (clk_en) begin
      vme_irq_q   <= irq_link.request ? (8'h01 << req_level) : 8'h00;
      irq_level_q <= req_level;
    end
  end

  // ****************************************************************
  // slave response
  // ****************************************************************
  // drops with address strobe, so a missed cycle never drives the bus
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slave_sel_q   <= 1'b0;
      vme_dtack_q   <= 1'b0;
      vme_data_oe_q <= 1'b0;
      vme_data_q    <= 8'h00;
    end else if (clk_en) begin
      slave_sel_q   <= hit;
      vme_dtack_q   <= (hit || irq_link.ack_hit) && vme_as;
      vme_data_oe_q <= irq_link.ack_hit && vme_as;
      vme_data_q    <= irq_link.ack_data;
    end
  end

  // ****************************************************************
  // arbitration grant
  // ****************************************************************
  logic [3:0] bg_s1_q;
  logic [3:0] bg_s2_q;
  logic [3:0] bg_use;
  logic [1:0] lvl;

  assign lvl = grant_level3_strap ? 2'h3 : 2'h0;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bg_s1_q <= 4'h0;
      bg_s2_q <= 4'h0;
    end else if (clk_en) begin
      bg_s1_q <= vme_bg_in;
      bg_s2_q <= bg_s1_q;
    end
  end

  // filtered grant needs two consecutive samples high
  assign bg_use = grant_filter_strap ? (bg_s1_q & bg_s2_q) : bg_s1_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      grant_level_q <= 2'h0;
      bus_granted_q <= 1'b0;
      vme_bg_out_q  <= 4'h0;
    end else if (clk_en) begin
      grant_level_q <= lvl;
      bus_granted_q <= bg_use[lvl];
      // no local request yet: pass every grant down the chain
      vme_bg_out_q  <= bg_use;
    end
  end

  // ****************************************************************
  // halt, watchdog and real-time clock
  // ****************************************************************
  logic rtc_tick;
  logic rtc_wr;

  assign rtc_wr = cpu_strobe && cpu_we && cpu_addr == RTC_LOCAL_ADDR;

  vsd_rtc #(
    .BASE_CYC (RTC_BASE_CYC)
  ) u_rtc (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .sel_we   (rtc_wr),
    .sel_data (rtc_sel_data),
    .sel_q    (rtc_sel_q),
    .tick_q   (rtc_tick)
  );

  // watchdog fires when a whole period passes with no kick
  logic kicked_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sysfail_q      <= 1'b0;
      wdog_enabled_q <= 1'b0;
      wdog_irq_q     <= 1'b0;
      kicked_q       <= 1'b0;
    end else if (clk_en) begin
      sysfail_q      <= halt_report_strap && cpu_halt;
      wdog_enabled_q <= watchdog_enable_strap &&
                        !debug_board_present;
      if (rtc_tick) begin
        kicked_q <= wdog_kick;
      end else if (wdog_kick) begin
        kicked_q <= 1'b1;
      end
      wdog_irq_q <= rtc_tick && !kicked_q && !wdog_kick &&
                    watchdog_enable_strap && !debug_board_present;
    end
  end

  // ****************************************************************
  // local decode and parity
  // ****************************************************************
  logic boot_hit;

  // small part decodes only in the lower half of the large window; the upper half is not selected
  assign boot_hit = cpu_addr[23:BOOT_AW_LARGE] ==
                    BOOT_ROM_BASE[23:BOOT_AW_LARGE] &&
                    (boot_rom_size_strap ||
                     !cpu_addr[BOOT_AW_SMALL]);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rtc_cs_q      <= 1'b0;
      boot_cs_q     <= 1'b0;
      mem_wparity_q <= 1'b0;
      parity_err_q  <= 1'b0;
    end else if (clk_en) begin
      rtc_cs_q      <= cpu_strobe && cpu_addr == RTC_LOCAL_ADDR;
      boot_cs_q     <= cpu_strobe && !cpu_we && boot_hit;
      mem_wparity_q <= ^mem_wdata;
      parity_err_q  <= mem_rd_valid && (^mem_rdata != mem_rparity);
    end
  end

endmodule
`default_nettype wire

// File: vsd_pkg.sv
// package: constants and types for the vme slave decode and interrupter block
package vsd_pkg;

  // ****************************************************************
  // clock and real-time clock timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned RTC_MIN_US      = 819;
  localparam int unsigned RTC_DEF_MS      = 52;
  localparam int unsigned RTC_MAX_MS      = 104;
  // eight periods, doubling from the shortest; entry 6 is the power-up one
  localparam logic [2:0]  RTC_SEL_DEFAULT = 3'h6;
  localparam int unsigned RTC_MIN_CYC     = RTC_MIN_US * CLK_MHZ;

  // ****************************************************************
  // address spaces and decode
  // ****************************************************************
  localparam logic [5:0]  AM_EXT_BASE     = 6'h08;
  localparam logic [5:0]  AM_STD_BASE     = 6'h38;
  localparam logic [5:0]  AM_SPACE_MASK   = 6'h38;
  localparam logic [2:0]  AM_CODE_USER_D  = 3'h1;
  localparam logic [2:0]  AM_CODE_USER_P  = 3'h2;
  localparam logic [2:0]  AM_CODE_SUP_D   = 3'h5;
  localparam logic [2:0]  AM_CODE_SUP_P   = 3'h6;
  localparam int unsigned WIN_LSB         = 14;
  localparam int unsigned MID_LSB         = 16;
  localparam int unsigned UPPER_LSB       = 24;
  localparam logic [7:0]  MID_STRAPS_DEF  = 8'h0F;
  localparam logic [31:0] WIN_BASE_DEF    = 32'h000F_0000;

  // ****************************************************************
  // local processor map
  // ****************************************************************
  localparam logic [23:0] RTC_LOCAL_ADDR  = 24'h60_0000;
  localparam logic [23:0] BOOT_ROM_BASE   = 24'h00_0000;
  localparam int unsigned BOOT_AW_SMALL   = 15;
  localparam int unsigned BOOT_AW_LARGE   = 16;

  // ****************************************************************
  // interrupt defaults and iack handshake
  // ****************************************************************
  localparam logic [2:0]  IRQ_LEVEL_DEF   = 3'h2;
  localparam logic [7:0]  VECTOR_DEF      = 8'h40;

  typedef enum logic [1:0] {
    VSD_IDLE,
    VSD_ACK,
    VSD_WAIT_END
  } vsd_cyc_t;

endpackage

// File: vsd_irq_if.sv
// interface: interrupt request and acknowledge between top and interrupter
`timescale 1ns/100ps
`default_nettype none
interface vsd_irq_if;
  logic       raise;
  logic [2:0] level;
  logic [7:0] vector;
  logic       iack_cycle;
  logic [2:0] iack_level;
  logic       request;
  logic       ack_hit;
  logic [7:0] ack_data;

  modport top (output raise, level, vector, iack_cycle, iack_level,
               input  request, ack_hit, ack_data);
  modport irq (input  raise, level, vector, iack_cycle, iack_level,
               output request, ack_hit, ack_data);
endinterface
`default_nettype wire

// File: vsd_interrupter.sv
// interrupter: holds the request until acknowledged at its level
`timescale 1ns/100ps
`default_nettype none
module vsd_interrupter
  import vsd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // link to top
  vsd_irq_if.irq   bus
);

  logic       request_q;
  logic       ack_hit_q;
  logic [7:0] ack_data_q;
  logic       match;

  assign match = bus.iack_cycle && request_q && (bus.iack_level == bus.level);
  assign bus.request  = request_q;
  assign bus.ack_hit  = ack_hit_q;
  assign bus.ack_data = ack_data_q;

  // a new raise in the acknowledge cycle wins, so no event is lost
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      request_q <= 1'b0;
    end else if (clk_en) begin
      if (bus.raise) begin
        request_q <= 1'b1;
      end else if (match) begin
        request_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_hit_q  <= 1'b0;
      ack_data_q <= 8'h00;
    end else if (clk_en) begin
      ack_hit_q  <= match;
      ack_data_q <= match ? bus.vector : 8'h00;
    end
  end

endmodule
`default_nettype wire

// File: vsd_rtc.sv
// real-time clock: periodic tick with eight software-selected periods
`timescale 1ns/100ps
`default_nettype none
module vsd_rtc
  import vsd_pkg::*;
#(
  parameter int unsigned BASE_CYC = RTC_MIN_CYC
)(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  // control
  input  wire logic       sel_we,
  input  wire logic [2:0] sel_data,
  // status
  output logic      [2:0] sel_q,
  output logic            tick_q
);

  localparam int unsigned CW = $clog2(BASE_CYC << 7) + 1;

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] limit;

  assign limit = CW'((BASE_CYC << sel_q) - 1);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sel_q <= RTC_SEL_DEFAULT;
    end else if (clk_en && sel_we) begin
      sel_q <= sel_data;
    end
  end

  // a new period restarts the count so the first tick is never short
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      tick_q <= 1'b0;
      if (sel_we || cnt_q >= limit) begin
        cnt_q  <= '0;
        tick_q <= !sel_we;
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

endmodule
`default_nettype wire

// File: vsd_top_properties.sv
// checker: port-level properties of the vme slave decode block
`timescale 1ns/100ps
`default_nettype none
module vsd_top_props
  import vsd_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        sys_rst,
  // inputs watched
  input wire logic        vme_as,
  input wire logic        vme_iack,
  input wire logic [7:0]  vector_byte_straps,
  input wire logic        halt_report_strap,
  input wire logic        cpu_halt,
  input wire logic        watchdog_enable_strap,
  input wire logic        debug_board_present,
  input wire logic        grant_level3_strap,
  input wire logic [23:0] cpu_addr,
  input wire logic        cpu_strobe,
  input wire logic [7:0]  mem_wdata,
  // outputs watched
  input wire logic        slave_sel_q,
  input wire logic        vme_dtack_q,
  input wire logic        vme_data_oe_q,
  input wire logic [7:0]  vme_data_q,
  input wire logic [7:0]  vme_irq_q,
  input wire logic [1:0]  grant_level_q,
  input wire logic        sysfail_q,
  input wire logic        wdog_enabled_q,
  input wire logic        wdog_irq_q,
  input wire logic        rtc_cs_q,
  input wire logic        mem_wparity_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // ********
  // slave and acknowledge
  // ********
  a_sel_needs_as: assert property (slave_sel_q |-> $past(vme_as) ||
    $past(vme_as, 2)) else $error("window hit without a cycle");
  a_dtack_needs_sel: assert property (vme_dtack_q && !vme_data_oe_q |->
    slave_sel_q) else $error("dtack outside the window");
  a_vector_strap: assert property (vme_data_oe_q |-> vme_dtack_q &&
    vme_data_q == vector_byte_straps) else $error("vector mismatch");
  a_oe_needs_iack: assert property ($rose(vme_data_oe_q) |->
    $past(vme_iack) && $past(vme_as)) else $error("vector without iack");
  a_irq_onehot: assert property ($onehot0(vme_irq_q))
    else $error("more than one request level");
  a_irq_holds: assert property ($changed(vme_irq_q) &&
    $past(vme_irq_q) != 8'h00 |-> $past(vme_as && vme_iack, 2))
    else $error("request dropped without iack");

  // ********
  // straps and local decode
  // ********
  a_sysfail_off: assert property ((!halt_report_strap)[*2] |->
    !sysfail_q) else $error("sysfail with strap removed");
  a_sysfail_on: assert property ((cpu_halt && halt_report_strap)[*3]
    |-> sysfail_q) else $error("halt not reported");
  a_wdog_off: assert property ((!watchdog_enable_strap ||
    debug_board_present)[*2] |-> !wdog_enabled_q && !wdog_irq_q)
    else $error("watchdog active while disabled");
  a_wdog_on: assert property ((watchdog_enable_strap &&
    !debug_board_present)[*3] |-> wdog_enabled_q)
    else $error("watchdog not enabled");
  a_grant_level: assert property (grant_level3_strap[*2] |->
    grant_level_q == 2'h3) else $error("grant level not 3");
  a_rtc_decode: assert property (rtc_cs_q |-> $past(cpu_strobe) &&
    $past(cpu_addr) == RTC_LOCAL_ADDR) else $error("rtc select misplaced");
  a_parity_gen: assert property (!$past(sys_rst) |->
    mem_wparity_q == ^$past(mem_wdata)) else $error("write parity wrong");

  c_slave_hit: cover property (slave_sel_q && vme_dtack_q);
  c_vector: cover property (vme_data_oe_q);
  c_wdog: cover property (wdog_irq_q);
  c_sysfail: cover property (sysfail_q);
endmodule

bind vsd_top vsd_top_props vsd_top_props_i (
  .clock, .sys_rst, .vme_as, .vme_iack, .vector_byte_straps,
  .halt_report_strap, .cpu_halt, .watchdog_enable_strap,
  .debug_board_present, .grant_level3_strap, .cpu_addr, .cpu_strobe,
  .mem_wdata, .slave_sel_q, .vme_dtack_q, .vme_data_oe_q, .vme_data_q,
  .vme_irq_q, .grant_level_q, .sysfail_q, .wdog_enabled_q, .wdog_irq_q,
  .rtc_cs_q, .mem_wparity_q
);
`default_nettype wire

// File: vsd_host.sv
// partner: vme master and interrupt handler driving slave and iack cycles
`timescale 1ns/100ps
`default_nettype none
module vsd_host (
  // clock
  input  wire logic        clock,
  // slave answer
  input  wire logic        dtack,
  input  wire logic [7:0]  data,
  // master drive
  output logic             as,
  output logic             iack,
  output logic [5:0]       am,
  output logic [31:0]      addr,
  output logic [2:0]       level
);
  initial begin
    as = 1'h0;
    iack = 1'h0;
    am = 6'h00;
    addr = 32'h0000_0000;
    level = 3'h0;
  end

  // holds the cycle until dtack; no answer in six edges counts as a miss
  task automatic cyc(input logic ack, input logic [5:0] m,
                     input logic [31:0] a, input logic [2:0] l,
                     output logic hit, output logic [7:0] d);
    hit = 1'h0;
    d = 8'h00;
    @(posedge clock);
    as <= 1'h1;
    iack <= ack;
    am <= m;
    addr <= a;
    level <= l;
    for (int n = 0; n < 6 && !hit; n++) begin
      @(posedge clock);
      hit = dtack;
      d = data;
    end
    // released as and iack drop to zero; am, addr and level show the inverse, never the stale value
    as <= 1'h0;
    iack <= 1'h0;
    am <= ~m;
    addr <= ~a;
    level <= ~l;
    repeat (3) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// File: testbench.sv
// testbench: scenarios for the vme slave decode and interrupter block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import vsd_pkg::*;
  logic        clock, sys_rst, clk_en, irq_raise, cpu_halt, wdog_kick;
  logic        program_space_strap, data_space_strap, standard_space_strap;
  logic        supervisor_space_strap, base_bit15_strap, base_bit14_strap;
  logic [7:0]  base_mid_address_straps, base_upper_address_straps;
  logic [6:0]  irq_request_level_straps;
  logic        iack_level_strap_msb, iack_level_strap_mid;
  logic        iack_level_strap_lsb, watchdog_enable_strap;
  logic        halt_report_strap, grant_level3_strap, grant_filter_strap;
  logic        boot_rom_size_strap, debug_board_present, vme_as, vme_iack;
  logic [7:0]  vector_byte_straps, vme_data_q, vme_irq_q, mem_wdata;
  logic [7:0]  mem_rdata;
  logic [5:0]  vme_am;
  logic [31:0] vme_addr;
  logic [2:0]  vme_iack_level, irq_level_q, rtc_sel_data, rtc_sel_q;
  logic        slave_sel_q, vme_dtack_q, vme_data_oe_q, bus_granted_q;
  logic [3:0]  vme_bg_in, vme_bg_out_q;
  logic [1:0]  grant_level_q;
  logic        sysfail_q, wdog_enabled_q, wdog_irq_q, cpu_strobe, cpu_we;
  logic        rtc_cs_q, boot_cs_q, mem_rparity, mem_rd_valid;
  logic        mem_wparity_q, parity_err_q;
  logic [23:0] cpu_addr;
  int          num_errors, checked, cycles;

  vsd_top #(.RTC_BASE_CYC(8)) vsd_top_i (.clock, .sys_rst, .clk_en,
    .program_space_strap, .data_space_strap, .standard_space_strap,
    .supervisor_space_strap, .base_mid_address_straps,
    .base_upper_address_straps, .base_bit15_strap, .base_bit14_strap,
    .irq_request_level_straps, .iack_level_strap_msb,
    .iack_level_strap_mid, .iack_level_strap_lsb, .vector_byte_straps,
    .watchdog_enable_strap, .halt_report_strap, .grant_level3_strap,
    .grant_filter_strap, .boot_rom_size_strap, .debug_board_present,
    .vme_as, .vme_iack, .vme_am, .vme_addr, .vme_iack_level, .slave_sel_q,
    .vme_dtack_q, .vme_data_oe_q, .vme_data_q, .irq_raise, .vme_irq_q,
    .irq_level_q, .vme_bg_in, .vme_bg_out_q, .grant_level_q,
    .bus_granted_q, .cpu_halt, .wdog_kick, .sysfail_q, .wdog_enabled_q,
    .wdog_irq_q, .cpu_addr, .cpu_strobe, .cpu_we, .rtc_sel_data, .rtc_cs_q,
    .boot_cs_q, .rtc_sel_q, .mem_wdata, .mem_rdata, .mem_rparity,
    .mem_rd_valid, .mem_wparity_q, .parity_err_q);

  vsd_host vsd_host_i (.clock, .dtack(vme_dtack_q), .data(vme_data_q),
    .as(vme_as), .iack(vme_iack), .am(vme_am), .addr(vme_addr),
    .level(vme_iack_level));

  always #2 clock = ~clock;

  // ********
  // shared tasks
  // ********
  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("errors %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic factory;
    {program_space_strap, data_space_strap} <= 2'h3;
    {standard_space_strap, supervisor_space_strap} <= 2'h3;
    base_mid_address_straps <= 8'hF0;
    base_upper_address_straps <= 8'h00;
    {base_bit15_strap, base_bit14_strap} <= 2'h3;
    irq_request_level_straps <= 7'h02;
    {iack_level_strap_msb, iack_level_strap_mid,
     iack_level_strap_lsb} <= 3'h5;
    vector_byte_straps <= 8'h40;
    {watchdog_enable_strap, halt_report_strap} <= 2'h3;
    {grant_level3_strap, grant_filter_strap} <= 2'h2;
    {boot_rom_size_strap, debug_board_present} <= 2'h0;
  endtask

  task automatic raise;
    repeat (2) @(posedge clock);
    irq_raise <= 1'h1;
    @(posedge clock);
    irq_raise <= 1'h0;
    repeat (3) @(posedge clock);
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_window;
    logic       h;
    logic [7:0] d;
    logic [2:0] c;
    vsd_host_i.cyc(1'h0, 6'h3D, 32'h000F_3FFE, 3'h0, h, d);
    cmp("factory top", 32'h1, h);
    vsd_host_i.cyc(1'h0, 6'h3D, 32'h000F_4000, 3'h0, h, d);
    cmp("above window", 32'h0, h);
    for (int i = 0; i < 128; i++) begin
      c = {i[4], i[3], ~i[3]};
      {standard_space_strap, supervisor_space_strap} <= i[1:0];
      {program_space_strap, data_space_strap} <= i[6:5];
      vsd_host_i.cyc(1'h0, {i[2] ? 3'h7 : 3'h1, c}, 32'hFF0F_0000, 3'h0,
                     h, d);
      cmp("space", (i[2] == i[1]) && (c[2] == i[0]) &&
          (c[1] ? i[6] : i[5]), h);
    end
    standard_space_strap <= 1'h0;
    base_upper_address_straps <= 8'h5A;
    for (int b = 13; b < 32; b++) begin
      vsd_host_i.cyc(1'h0, 6'h0D, 32'hA50F_0000 ^ (32'h1 << b), 3'h0, h, d);
      cmp("base bit", b == 13, h);
    end
    factory();
  endtask

  task automatic t_irq;
    logic       h;
    logic [7:0] d;
    logic [7:0] v;
    // let the factory straps of the last scenario land first
    @(posedge clock);
    for (int l = 1; l < 8; l++) begin
      v = 8'hA5 ^ 8'(l);
      irq_request_level_straps <= 7'(7'h01 << (l - 1));
      {iack_level_strap_msb, iack_level_strap_mid,
       iack_level_strap_lsb} <= ~3'(l);
      vector_byte_straps <= v;
      raise();
      cmp("request", 32'h1 << l, vme_irq_q);
      vsd_host_i.cyc(1'h1, 6'h00, 32'h0, 3'(l ^ 1), h, d);
      cmp("wrong level", 32'h0, h);
      cmp("held", 32'h1 << l, vme_irq_q);
      vsd_host_i.cyc(1'h1, 6'h00, 32'h0, 3'(l), h, d);
      cmp("vector", v, d);
      cmp("released", 32'h0, vme_irq_q);
    end
    factory();
    raise();
    cmp("default level", 32'h2, irq_level_q);
    vsd_host_i.cyc(1'h1, 6'h00, 32'h0, 3'h2, h, d);
    cmp("default vector", 32'h40, d);
  endtask

  task automatic t_misc;
    cpu_halt <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      {debug_board_present, watchdog_enable_strap, halt_report_strap} <=
        i[2:0];
      repeat (4) @(posedge clock);
      cmp("sysfail", i[0], sysfail_q);
      cmp("watchdog", i[1] && !i[2], wdog_enabled_q);
    end
    cpu_halt <= 1'h0;
    factory();
    @(posedge clock);
    for (int f = 0; f < 2; f++) begin
      grant_filter_strap <= f[0];
      vme_bg_in <= 4'h0;
      repeat (4) @(posedge clock);
      vme_bg_in <= 4'h8;
      repeat (1 + f) @(posedge clock);
      #1 cmp("grant early", 32'h0, bus_granted_q);
      @(posedge clock);
      #1 cmp("grant", 32'h1, bus_granted_q);
      cmp("grant out", 32'h8, vme_bg_out_q);
      @(posedge clock);
    end
    for (int i = 0; i < 4; i++) begin
      mem_wdata <= 8'(8'h03 + i);
      mem_rdata <= 8'(8'h03 + i);
      mem_rparity <= ^(8'(8'h03 + i)) ^ i[0];
      mem_rd_valid <= 1'h1;
      boot_rom_size_strap <= i[1];
      {cpu_addr, cpu_strobe} <= {24'h00_8000, 1'h1};
      repeat (2) @(posedge clock);
      cmp("parity error", i[0], parity_err_q);
      cmp("boot select", i[1], boot_cs_q);
    end
    {mem_rd_valid, cpu_strobe} <= 2'h0;
  endtask

  task automatic t_rtc;
    int n;
    for (int j = 0; j < 4; j++) begin
      @(posedge clock);
      {cpu_addr, cpu_strobe, cpu_we} <= {RTC_LOCAL_ADDR, 2'h3};
      rtc_sel_data <= (j == 3) ? 3'h6 : 3'(j);
      @(posedge clock);
      {cpu_strobe, cpu_we} <= 2'h0;
      repeat (2) @(posedge clock);
      cmp("rtc select", (j == 3) ? 6 : j, rtc_sel_q);
      n = 0;
      while (wdog_irq_q !== 1'h1 && n < 2000) begin
        @(posedge clock);
        n++;
      end
      @(posedge clock);
      n = 1;
      while (wdog_irq_q !== 1'h1 && n < 2000) begin
        @(posedge clock);
        n++;
      end
      cmp("period", 8 << ((j == 3) ? 6 : j), n);
      if (j == 0) begin
        // a steady kick must hold back every watchdog pulse
        wdog_kick <= 1'h1;
        n = 0;
        repeat (40) begin
          @(posedge clock);
          if (wdog_irq_q !== 1'h0) n++;
        end
        wdog_kick <= 1'h0;
        cmp("kicked", 32'h0, n);
      end
    end
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    clock = 1'h0;
    sys_rst = 1'h1;
    clk_en = 1'h1;
    {irq_raise, cpu_halt, wdog_kick, cpu_strobe, cpu_we} = 5'h00;
    {mem_rparity, mem_rd_valid, mem_wdata, mem_rdata} = 18'h0_0000;
    {cpu_addr, rtc_sel_data, vme_bg_in} = 31'h0000_0000;
    num_errors = 0;
    checked = 0;
    cycles = 0;
    factory();
    repeat (12) @(posedge clock);
    sys_rst <= 1'h0;
    @(posedge clock);
    #1 cmp("rtc reset select", 32'h6, rtc_sel_q);
    t_window();
    t_irq();
    t_misc();
    t_rtc();
    test_done();
  end
endmodule
`default_nettype wire
